// >>> inc/pfsel_defs.svh
// Constants of the pin function selector block
`ifndef PFSEL_DEFS_SVH
`define PFSEL_DEFS_SVH
`define PFS_NREG 12
`define PFS_NPIN 48
`define PFS_RST 8'h00
`define PFS_IDX_D1 4'h3
`define PFS_IDX_J 4'hA
`define PFS_IDX_IFS 4'hB
`define PFS_MASK_D1 8'h3F
`define PFS_MASK_J 8'h0F
`define PFS_MASK_IFS 8'h7F
`define PFS_MASK_ALL 8'hFF
`define PFS_RESP_OK 2'h0
`define PFS_RESP_ERR 2'h2
`define PFS_BC 0
`define PFS_BD 8
`define PFS_BE 16
`define PFS_BF 24
`define PFS_G 8'h00
`define PFS_A 8'h80
`define PFS_L 8'hC0
`define PFS_K_GPIO 2'h0
`define PFS_K_PER 2'h1
`define PFS_K_ANA 2'h2
`define PFS_K_LCD 2'h3
`endif

// >>> inc/pfsel_pkg.sv
// Types of the pin function selector block
package pfsel_pkg;
  typedef struct packed {
    logic [31:0] fn_o;
    logic [31:0] fn_oe;
  } pfsel_periph_s;
  typedef struct packed {
    logic [3:0] ptck;
    logic [2:0] stck;
  } pfsel_tck_s;
endpackage : pfsel_pkg

// >>> verilog/pfsel_top.sv
// Pin function selector for ports C to J with AXI4-Lite registers
//
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pfsel_defs.svh"
module pfsel_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [47:0]           pin_in,
  input  wire logic [47:0]           gpio_out,
  input  wire logic [47:0]           gpio_oe,
  input  wire logic [7:0]            port_b_pin_in,
  input  wire pfsel_pkg::pfsel_periph_s periph,
  output logic [47:0]                pin_out,
  output logic [47:0]                pin_oe,
  output logic [47:0]                pin_ana_en,
  output logic [47:0]                pin_lcd_en,
  output logic [31:0]                fn_in,
  output pfsel_pkg::pfsel_tck_s      tck
);
  import pfsel_pkg::*;

  // ---------------------------------------------------------------
  // Function table, per pin {code3, code2, code1, code0}
  // ---------------------------------------------------------------
  // Peripheral index: 00-07 timer out, 08-0A std timer out, 0B/0C TX0/TX1,
  // 0D/0E comparator out, 0F-12 SPI sck/sdo/sdi/cs, 13-16 serial
  // sck/sdo/sda/cs, 17/18 RX0/RX1
  function automatic logic [7:0] pd(input logic [4:0] i);
    pd = {3'h2, i};
  endfunction : pd

  localparam logic [7:0] G = `PFS_G;
  localparam logic [7:0] A = `PFS_A;
  localparam logic [7:0] L = `PFS_L;

  localparam logic [31:0] FTAB [`PFS_NPIN] = '{
    {L, A, A, G},                 // C0
    {pd(5'h0D), A, A, G},         // C1
    {L, pd(5'h00), A, G},         // C2
    {L, A, pd(5'h04), G},         // C3
    {L, pd(5'h01), A, G},         // C4
    {L, A, pd(5'h05), G},         // C5
    {L, pd(5'h08), A, G},         // C6
    {L, A, pd(5'h06), G},         // C7
    {L, A, pd(5'h09), G},         // D0
    {L, A, pd(5'h18), G},         // D1
    {A, pd(5'h0C), pd(5'h02), G}, // D2
    {L, A, pd(5'h07), G},         // D3
    {A, pd(5'h17), pd(5'h03), G}, // D4
    {L, A, pd(5'h0B), G},         // D5
    {L, pd(5'h0E), pd(5'h0A), G}, // D6
    {G, G, G, G},                 // D7
    {L, pd(5'h12), G, G},         // E0
    {L, pd(5'h10), pd(5'h08), G}, // E1
    {L, pd(5'h11), G, G},         // E2
    {L, pd(5'h0F), pd(5'h01), G}, // E3
    {A, G, G, G},                 // E4
    {L, G, G, G},                 // E5
    {L, G, G, G},                 // E6
    {L, G, G, G},                 // E7
    {L, pd(5'h16), pd(5'h07), G}, // F0
    {L, pd(5'h14), pd(5'h06), G}, // F1
    {L, pd(5'h15), G, G},         // F2
    {L, pd(5'h13), G, G},         // F3
    {A, G, G, G},                 // F4
    {A, pd(5'h00), G, G},         // F5
    {L, A, pd(5'h18), G},         // F6
    {A, pd(5'h0C), pd(5'h0A), G}, // F7
    {L, G, G, G},                 // G0
    {L, G, G, G},                 // G1
    {L, G, G, G},                 // G2
    {L, G, G, G},                 // G3
    {L, L, G, G},                 // G4
    {L, L, G, G},                 // G5
    {L, L, G, G},                 // G6
    {L, L, G, G},                 // G7
    {L, pd(5'h04), G, G},         // J0
    {L, pd(5'h05), G, G},         // J1
    {G, G, G, G},
    {G, G, G, G},
    {G, G, G, G},
    {G, G, G, G},
    {G, G, G, G},
    {G, G, G, G}
  };

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [7:0] sel_r [`PFS_NREG];

  function automatic logic [7:0] wmask(input logic [3:0] i);
    case (i)
      `PFS_IDX_D1:  wmask = `PFS_MASK_D1;
      `PFS_IDX_J:   wmask = `PFS_MASK_J;
      `PFS_IDX_IFS: wmask = `PFS_MASK_IFS;
      default:      wmask = `PFS_MASK_ALL;
    endcase
  endfunction : wmask

  function automatic logic hit(input logic [ADDR_W-1:0] a);
    hit = (a[ADDR_W-1:6] == '0) && (a[5:2] < 4'(`PFS_NREG));
  endfunction : hit

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  logic              aw_hold_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic              w_hold_r;
  logic [31:0]       w_data_r;
  logic              w_strb_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              have_aw;
  logic              have_w;
  logic              do_wr;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic              wr_strb;

  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready  = !w_hold_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign have_aw = aw_hold_r || (s_axi_awvalid && s_axi_awready);
  assign have_w  = w_hold_r || (s_axi_wvalid && s_axi_wready);
  assign do_wr   = have_aw && have_w && !bvalid_r;
  assign wr_addr = aw_hold_r ? aw_addr_r : s_axi_awaddr;
  assign wr_data = w_hold_r ? w_data_r : s_axi_wdata;
  assign wr_strb = w_hold_r ? w_strb_r : s_axi_wstrb[0];

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= '0;
      w_hold_r  <= 1'b0;
      w_data_r  <= '0;
      w_strb_r  <= 1'b0;
    end else if (do_wr) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb[0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `PFS_RESP_OK;
    end else if (do_wr) begin
      bvalid_r <= 1'b1;
      bresp_r  <= hit(wr_addr) ? `PFS_RESP_OK : `PFS_RESP_ERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Only byte lane 0 carries a selector; unused bits are never stored
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `PFS_NREG; i++) begin
        sel_r[i] <= `PFS_RST;
      end
    end else if (do_wr && hit(wr_addr) && wr_strb) begin
      sel_r[wr_addr[5:2]] <= wr_data[7:0] & wmask(wr_addr[5:2]);
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= `PFS_RESP_OK;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      if (hit(s_axi_araddr)) begin
        rdata_r <= {24'h000000, sel_r[s_axi_araddr[5:2]]};
        rresp_r <= `PFS_RESP_OK;
      end else begin
        rdata_r <= '0;
        rresp_r <= `PFS_RESP_ERR;
      end
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Per pin routing
  // ---------------------------------------------------------------
  logic [7:0] desc [`PFS_NPIN];

  for (genvar g = 0; g < `PFS_NPIN; g++) begin : g_pin
    localparam int RI = g / 4;
    localparam int FB = (g % 4) * 2;
    logic [1:0] code;
    logic [1:0] kind;
    logic [4:0] idx;
    assign code    = sel_r[RI][FB +: 2];
    assign desc[g] = FTAB[g][{code, 3'h0} +: 8];
    assign kind    = desc[g][7:6];
    assign idx     = desc[g][4:0];

    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        pin_out[g]    <= 1'b0;
        pin_oe[g]     <= 1'b0;
        pin_ana_en[g] <= 1'b0;
        pin_lcd_en[g] <= 1'b0;
      end else begin
        case (kind)
          `PFS_K_GPIO: begin
            pin_out[g] <= gpio_out[g];
            pin_oe[g]  <= gpio_oe[g];
          end
          `PFS_K_PER: begin
            pin_out[g] <= periph.fn_o[idx];
            pin_oe[g]  <= periph.fn_oe[idx];
          end
          default: begin
            pin_out[g] <= 1'b0;
            pin_oe[g]  <= 1'b0;
          end
        endcase
        pin_ana_en[g] <= (kind == `PFS_K_ANA);
        pin_lcd_en[g] <= (kind == `PFS_K_LCD);
      end
    end
  end

  // Peripheral inputs see a pin only while it selects that function
  logic [31:0] fin;

  always_comb begin
    fin = '0;
    for (int g = 0; g < `PFS_NPIN; g++) begin
      if (desc[g][7:6] == `PFS_K_PER) begin
        fin[desc[g][4:0]] = fin[desc[g][4:0]] | pin_in[g];
      end
    end
  end

  // ---------------------------------------------------------------
  // Timer clock source selection
  // ---------------------------------------------------------------
  logic [7:0] ifs;
  assign ifs = sel_r[`PFS_IDX_IFS];

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fn_in <= '0;
      tck   <= '0;
    end else begin
      fn_in <= fin;
      tck.ptck[3] <= ifs[6] ? port_b_pin_in[1] : pin_in[`PFS_BD+5];
      tck.ptck[2] <= ifs[5] ? port_b_pin_in[2] : pin_in[`PFS_BD+3];
      tck.ptck[1] <= ifs[4] ? pin_in[`PFS_BE+2] : pin_in[`PFS_BC+5];
      tck.ptck[0] <= ifs[3] ? pin_in[`PFS_BF+4] : pin_in[`PFS_BC+3];
      tck.stck[2] <= ifs[2] ? port_b_pin_in[0] : pin_in[`PFS_BF+6];
      tck.stck[1] <= ifs[1] ? port_b_pin_in[7] : pin_in[`PFS_BD+1];
      tck.stck[0] <= ifs[0] ? pin_in[`PFS_BE+0] : pin_in[`PFS_BC+7];
    end
  end
endmodule : pfsel_top
`default_nettype wire

// >>> dv/pfsel_top_chk_sva.sv
// Bus and pin routing checker for the pin function selector
`timescale 1ns/1ps
`default_nettype none
module pfsel_top_chk #(
  parameter int ADDR_W = 8
) (
  input wire logic              sys_clk,
  input wire logic              nrst,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [47:0]       pin_oe,
  input wire logic [47:0]       pin_ana_en,
  input wire logic [47:0]       pin_lcd_en
);
  logic [ADDR_W-1:0] rd_addr_r;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Address of the read in flight
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) rd_addr_r <= '0;
    else if (s_axi_arvalid && s_axi_arready) rd_addr_r <= s_axi_araddr;
  end
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("write response late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("second read taken");
  a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_d_high_gap: assert property (s_axi_rvalid && rd_addr_r == ADDR_W'(12) |->
    s_axi_rdata[7:6] == 2'h0) else $error("unimplemented bits read set");
  a_unmapped_err: assert property (s_axi_rvalid && rd_addr_r >= ADDR_W'(48) |->
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000) else $error("unmapped read accepted");
  a_drive_off: assert property (((pin_ana_en | pin_lcd_en) & pin_oe) == 48'h0000_0000_0000)
    else $error("pin driven under analog or lcd use");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_bad_read: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_lcd_on: cover property ($rose(|pin_lcd_en));
endmodule : pfsel_top_chk
bind pfsel_top pfsel_top_chk #(.ADDR_W(ADDR_W)) pfsel_top_chk_i (.sys_clk, .nrst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .pin_oe, .pin_ana_en, .pin_lcd_en);
`default_nettype wire

// >>> dv/pfsel_far_model.sv
// Far-side model: package pins and peripheral outputs
`timescale 1ns/1ps
`default_nettype none
module pfsel_far_model (
  input  wire logic [47:0]     pin_out,
  input  wire logic [47:0]     pin_oe,
  input  wire logic [47:0]     ext_lvl,
  input  wire logic [31:0]     fn_val,
  input  wire logic [31:0]     fn_en,
  output logic [47:0]          pin_in,
  output pfsel_pkg::pfsel_periph_s periph
);
  import pfsel_pkg::*;
  // Undriven pins settle to the board level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
  assign periph = '{fn_o: fn_val, fn_oe: fn_en};
endmodule : pfsel_far_model
`default_nettype wire

// >>> dv/pfsel_top_tb_top.sv
// Self-checking bench for the pin function selector
`timescale 1ns/1ps
`default_nettype none
module pfsel_top_tb_top;
  import pfsel_pkg::*;
  logic          sys_clk = 1'b0;
  logic          nrst = 1'b0;
  logic [7:0]    s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, port_b_pin_in = 8'h00, a, b, m;
  logic [31:0]   s_axi_wdata = 32'h0000_0000, s_axi_rdata, fn_in;
  logic [3:0]    s_axi_wstrb = 4'hF;
  logic          s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic          s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]    s_axi_bresp, s_axi_rresp;
  logic [47:0]   pin_in, pin_out, pin_oe, pin_ana_en, pin_lcd_en, x;
  logic [47:0]   gpio_out = 48'hA5A5_5A5A_C33C, gpio_oe = 48'h6C93_A55A_F00F, ext_lvl = 48'h0;
  logic [31:0]   fn_val = 32'h5A5A_36C9, fn_en = 32'hFE7F_EFFF;
  pfsel_periph_s periph;
  pfsel_tck_s    tck;
  int            err_count = 0, total_checks = 0;
  // Entry: address, value, pin, kind (0 out, 1 analog, 2 lcd, 3 gpio), function
  localparam logic [31:0] RT [40] = '{32'h0040_0304, 32'h0080_0340, 32'h00C0_0380,
    32'h0020_0200, 32'h0010_0240, 32'h000C_010D, 32'h0004_0140,
    32'h0003_0080, 32'h0001_0040, 32'h0440_0706, 32'h0480_0740,
    32'h0810_0A02, 32'h0820_0A0C, 32'h0830_0A40, 32'h080C_0980,
    32'h0801_0809, 32'h0802_0840, 32'h0C04_0D0B, 32'h0C08_0D40,
    32'h0C01_0C03, 32'h0C03_0C40, 32'h1010_12C0, 32'h1030_1280,
    32'h1001_10C0, 32'h1003_1080, 32'h140C_1580, 32'h1402_14C0,
    32'h1403_1440, 32'h1840_1BC0, 32'h18C0_1B80, 32'h1C08_1D00,
    32'h1C0C_1D40, 32'h2002_20C0, 32'h20C0_2380, 32'h2401_24C0,
    32'h2402_2480, 32'h24C0_2780, 32'h2801_28C0, 32'h2802_2804, 32'h2803_2880};
  pfsel_top pfsel_top_i (.sys_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pin_in, .gpio_out, .gpio_oe, .port_b_pin_in, .periph,
    .pin_out, .pin_oe, .pin_ana_en, .pin_lcd_en, .fn_in, .tck);
  pfsel_far_model pfsel_far_model_i (.pin_out, .pin_oe, .ext_lvl, .fn_val, .fn_en, .pin_in,
    .periph);
  always #4 sys_clk = ~sys_clk;
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] ad, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (s_axi_bvalid !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk(48'(n >= 200), 48'h0);
    chk(48'(s_axi_bresp), 48'(er));
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] ad, input logic [7:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (s_axi_rvalid !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk(48'(n >= 200), 48'h0);
    chk(48'({s_axi_rresp, s_axi_rdata}), 48'({er, 24'h000000, ed}));
  endtask : axi_rd
  task automatic route(input logic [31:0] e);
    logic [3:0] g;
    logic [3:0] w;
    int         p;
    p = int'(e[15:8]);
    axi_wr(e[31:24], e[23:16], 2'h0);
    repeat (3) @(posedge sys_clk);
    g = {pin_out[p], pin_oe[p], pin_ana_en[p], pin_lcd_en[p]};
    if (e[7] ^ e[6]) g[3] = 1'b0;
    w = (e[7:6] == 2'h0) ? {fn_val[e[5:0]], fn_en[e[5:0]], 2'b00} : (e[7:6] == 2'h1) ? 4'h2 :
        (e[7:6] == 2'h2) ? 4'h1 : {gpio_out[p], gpio_oe[p], 2'b00};
    chk(48'(g), 48'(w));
    axi_wr(e[31:24], 8'h00, 2'h0);
    repeat (3) @(posedge sys_clk);
    chk(48'({pin_out[p], pin_oe[p], pin_ana_en[p], pin_lcd_en[p]}),
        48'({gpio_out[p], gpio_oe[p], 2'b00}));
  endtask : route
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      m = (i == 3) ? 8'h3F : (i == 10) ? 8'h0F : (i == 11) ? 8'h7F : 8'hFF;
      a = 8'(i * 4);
      axi_rd(a, 8'h00, 2'h0);
      axi_wr(a, 8'hFF, 2'h0);
      axi_rd(a, m, 2'h0);
      s_axi_wstrb <= 4'hE;
      axi_wr(a, 8'h00, 2'h0);
      s_axi_wstrb <= 4'hF;
      axi_rd(a, m, 2'h0);
      axi_wr(a, 8'h00, 2'h0);
    end
    axi_wr(8'h30, 8'hFF, 2'h2);
    axi_rd(8'h30, 8'h00, 2'h2);
    foreach (RT[i]) route(RT[i]);
    gpio_oe <= 48'h0;
    for (int k = 0; k < 2; k++) begin
      ext_lvl <= (k != 0) ? 48'h9C3A_5E17_B46D : 48'h63C5_A1E8_4B92;
      port_b_pin_in <= (k != 0) ? 8'h5A : 8'hA5;
      axi_wr(8'h2C, 8'h00, 2'h0);
      axi_wr(8'h08, 8'h00, 2'h0);
      axi_wr(8'h0C, 8'h00, 2'h0);
      repeat (3) @(posedge sys_clk);
      x = ext_lvl;
      b = port_b_pin_in;
      chk(48'(tck), 48'({x[13], x[11], x[5], x[3], x[30], x[9], x[7]}));
      chk(48'(fn_in[24:23]), 48'h0);
      axi_wr(8'h2C, 8'h7F, 2'h0);
      axi_wr(8'h08, 8'h04, 2'h0);
      axi_wr(8'h0C, 8'h02, 2'h0);
      repeat (3) @(posedge sys_clk);
      chk(48'(tck), 48'({b[1], b[2], x[18], x[28], b[0], b[7], x[16]}));
      chk(48'(fn_in[24:23]), 48'({x[9], x[12]}));
    end
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    axi_rd(8'h2C, 8'h00, 2'h0);
    give_verdict();
  end
endmodule : pfsel_top_tb_top
`default_nettype wire
